// ==== sdram_ctl_pkg.sv ====
// Constants, types and command encodings for the bank state and clock-enable logic
// Function
// - Read-with-autoprecharge cut by read elsewhere: stop data after latency, precharge at read.
// - Read-with-autoprecharge cut by write elsewhere: stop read, start precharge at write.
// - Write-with-autoprecharge cut by read elsewhere: read data after two or three clocks.
// - Write recovery starts at interrupting read; precharge begins after it expires.
// - Last element written is the one captured a clock before the interrupting read.
// - Write-with-autoprecharge cut by write elsewhere: end burst, recover, then precharge.
// - Last element written is the one captured a clock before the interrupting write.
// - Power action uses current and previous clock-enable and the prior state.
// - Enable falling with banks idle: power-down, self refresh, deep power-down; bursts suspend.
// - Power-down exits on enable high with no-op; idle for the next edge.
// - Clock suspend exit at edge n accepts the next command at n plus one.
// - Burst-stop encoding terminates a burst with enable high, deep power-down with low.
// - Chip-select high ignores command; strobes decode to the eight listed commands.
// - Each bank accepts only the commands its state allows.
// - Precharge during a plain burst in that bank truncates it and closes the row.
// - Bank is reading or writing until the burst ends; row-active only when quiet.
// - Activated bank becomes row-active once the activate-to-column delay elapses.
package sdram_ctl_pkg;

  localparam int CLOCK_MHZ          = 200;
  localparam int NUM_BANKS          = 4;
  localparam int BANK_BITS          = 2;
  localparam int TIMER_BITS         = 8;
  localparam int BURST_BITS         = 4;
  localparam int ADDR_AP_BIT        = 10;

  // Timing figures in ns except the mode-load count in cycles, counts derived with rounding up
  localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
  localparam int PRECHARGE_PERIOD_NS         = 20;
  localparam int WRITE_RECOVERY_TIME_NS      = 15;
  localparam int SELF_REFRESH_EXIT_TIME_NS   = 120;
  localparam int REFRESH_CYCLE_NS            = 80;
  localparam int MODE_LOAD_CYCLES            = 2;
  localparam int RCD_CYC = (ACTIVATE_TO_COLUMN_DELAY_NS * CLOCK_MHZ + 999) / 1000;
  localparam int RP_CYC  = (PRECHARGE_PERIOD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int WR_CYC  = (WRITE_RECOVERY_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int XSR_CYC = (SELF_REFRESH_EXIT_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int RC_CYC  = (REFRESH_CYCLE_NS * CLOCK_MHZ + 999) / 1000;

  localparam logic [1:0] CAS_LAT_MIN = 2'h2;
  localparam logic [1:0] CAS_LAT_MAX = 2'h3;

  typedef enum logic [3:0] {
    CMD_INHIBIT   = 4'h0,
    CMD_NOP       = 4'h1,
    CMD_ACTIVATE  = 4'h2,
    CMD_READ      = 4'h3,
    CMD_WRITE     = 4'h4,
    CMD_PRECHARGE = 4'h5,
    CMD_REFRESH   = 4'h6,
    CMD_LOAD_MODE = 4'h7,
    CMD_BURST_STOP= 4'h8
  } cmd_t;

  typedef enum logic [2:0] {
    BANK_IDLE       = 3'h0,
    BANK_ACTIVATING = 3'h1,
    BANK_ACTIVE     = 3'h2,
    BANK_READ       = 3'h3,
    BANK_WRITE      = 3'h4,
    BANK_READ_AP    = 3'h5,
    BANK_WRITE_AP   = 3'h6,
    BANK_PRECHARGE  = 3'h7
  } bank_state_t;

  typedef enum logic [2:0] {
    PWR_RUN       = 3'h0,
    PWR_DOWN      = 3'h1,
    PWR_SELF_REF  = 3'h2,
    PWR_DEEP      = 3'h3,
    PWR_SUSPEND   = 3'h4,
    PWR_SR_EXIT   = 3'h5,
    PWR_BUSY      = 3'h6
  } pwr_state_t;

  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 16;

endpackage

// ==== sdram_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sdram_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_st_t;

  logic [WIDTH-1:0] mem_q [DEPTH];
  fifo_st_t st_q;
  fifo_st_t st_d;
  logic     full;
  logic     empty;
  logic     push;
  logic     pop;

  // Full when pointers differ only in the wrap bit
  assign full     = (st_q.wr_ptr[AW] != st_q.rd_ptr[AW]) && (st_q.wr_ptr[AW-1:0] == st_q.rd_ptr[AW-1:0]);
  assign empty    = (st_q.wr_ptr == st_q.rd_ptr);
  assign in_ready = !full;
  assign push     = in_valid && !full;
  // Output stage refills whenever it is free or being taken
  assign pop      = !empty && (!st_q.out_valid || out_ready);
  assign out_valid = st_q.out_valid;
  assign out_data  = st_q.out_data;

  // Pointer and output stage update
  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      st_d.rd_ptr    = st_q.rd_ptr + 1'b1;
      st_d.out_valid = 1'b1;
      st_d.out_data  = mem_q[st_q.rd_ptr[AW-1:0]];
    end
    else if (out_ready)
    begin
      st_d.out_valid = 1'b0;
    end
  end

  // Storage array, kept out of the reset tree
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[st_q.wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// ==== sdram_bank_ctrl.sv ====
// Command decode, per-bank state, clock-enable power states and concurrent auto precharge
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_ctrl
  import sdram_ctl_pkg::*;
#(
  parameter int NBANK = NUM_BANKS
) (
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire logic                 cke,
  input  wire logic                 chip_select_n,
  input  wire logic                 row_strobe_n,
  input  wire logic                 col_strobe_n,
  input  wire logic                 write_enable_n,
  input  wire logic [BANK_BITS-1:0] bank_addr,
  input  wire logic                 auto_precharge,
  input  wire logic                 all_banks,
  input  wire logic [1:0]           cas_latency,
  input  wire logic [BURST_BITS-1:0] burst_length,
  input  wire logic [DATA_W-1:0]    write_data,
  input  wire logic                 write_mask,
  output logic                      wr_out_valid,
  input  wire logic                 wr_out_ready,
  output logic      [DATA_W-1:0]    wr_out_data,
  output logic                      fifo_ready,
  output logic                      read_data_enable,
  output logic      [BANK_BITS-1:0] read_data_bank,
  output logic      [2:0]           power_state,
  output logic      [3*NBANK-1:0]   bank_states,
  output logic                      cmd_illegal
);

  typedef struct packed {
    logic [3*NBANK-1:0]          bank;
    logic [TIMER_BITS*NBANK-1:0] timer;
    logic [BURST_BITS*NBANK-1:0] burst;
    logic [NBANK-1:0]            wr_recover;
    logic [TIMER_BITS-1:0]       pwr_timer;
    logic [2:0]                  pwr;
    logic                        cke_prev;
    logic [3:0]                  rd_pipe;
    logic [3*BANK_BITS-1:0]      rd_bank_pipe;
    logic                        rd_en;
    logic [BANK_BITS-1:0]        rd_bank;
    logic                        illegal;
  } ctl_st_t;

  // Two-stage synchronisers for every pin input except cas_latency and burst_length
  logic [1:0] cke_sync_q;
  logic [4:0] cmd_s1_q;
  logic [4:0] cmd_s2_q;
  logic [BANK_BITS+1:0] adr_s1_q;
  logic [BANK_BITS+1:0] adr_s2_q;
  logic [DATA_W:0] dat_s1_q;
  logic [DATA_W:0] dat_s2_q;

  ctl_st_t st_q;
  ctl_st_t st_d;
  cmd_t    cmd;
  logic    cke_now;
  logic    cke_was;
  logic    all_idle;
  logic    wr_push;
  logic [DATA_W-1:0] wr_push_data;
  logic    cmd_bank_sel;

  // Strobe decode, shared by command path and power logic
  function automatic cmd_t decode_cmd(input logic [3:0] s);
    cmd_t c;
    c = CMD_INHIBIT;
    if (!s[3])
    begin
      case (s[2:0])
        3'h7:    c = CMD_NOP;
        3'h3:    c = CMD_ACTIVATE;
        3'h5:    c = CMD_READ;
        3'h4:    c = CMD_WRITE;
        3'h2:    c = CMD_PRECHARGE;
        3'h1:    c = CMD_REFRESH;
        3'h0:    c = CMD_LOAD_MODE;
        3'h6:    c = CMD_BURST_STOP;
        default: c = CMD_INHIBIT;
      endcase
    end
    return c;
  endfunction

  function automatic logic [TIMER_BITS-1:0] cyc(input int n);
    return TIMER_BITS'(n);
  endfunction

  // Pin capture: two flops before any logic looks at them
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      cke_sync_q <= '0;
      cmd_s1_q   <= 5'h1F;
      cmd_s2_q   <= 5'h1F;
      adr_s1_q   <= '0;
      adr_s2_q   <= '0;
      dat_s1_q   <= '0;
      dat_s2_q   <= '0;
    end
    else
    begin
      cke_sync_q <= {cke_sync_q[0], cke};
      cmd_s1_q   <= {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n, 1'b0};
      cmd_s2_q   <= cmd_s1_q;
      adr_s1_q   <= {bank_addr, auto_precharge, all_banks};
      adr_s2_q   <= adr_s1_q;
      dat_s1_q   <= {write_mask, write_data};
      dat_s2_q   <= dat_s1_q;
    end
  end

  assign cmd      = decode_cmd(cmd_s2_q[4:1]);
  assign cke_now  = cke_sync_q[1];
  assign cke_was  = st_q.cke_prev;

  // All banks idle check over the per-bank states
  always_comb
  begin
    all_idle = 1'b1;
    for (int b = 0; b < NBANK; b++)
    begin
      if (st_q.bank[3*b +: 3] != BANK_IDLE)
      begin
        all_idle = 1'b0;
      end
    end
  end

  // Main next-state logic
  always_comb
  begin
    logic [BANK_BITS-1:0] tb;
    logic                 ap;
    logic                 pa;
    logic                 run;
    logic                 burst_busy;
    bank_state_t          bs;
    tb = adr_s2_q[BANK_BITS+1:2];
    ap = adr_s2_q[1];
    pa = adr_s2_q[0];
    run = 1'b0;
    burst_busy = 1'b0;
    bs = BANK_IDLE;
    st_d = st_q;
    st_d.cke_prev = cke_now;
    st_d.illegal  = 1'b0;
    wr_push      = 1'b0;
    wr_push_data = dat_s2_q[DATA_W-1:0];
    cmd_bank_sel = 1'b0;
    for (int b = 0; b < NBANK; b++)
    begin
      if (st_q.bank[3*b +: 3] inside {BANK_READ, BANK_WRITE, BANK_READ_AP, BANK_WRITE_AP})
      begin
        burst_busy = 1'b1;
      end
    end
    // Power state from previous and current enable level and prior state
    case (pwr_state_t'(st_q.pwr))
      PWR_RUN:
      begin
        if (cke_was && !cke_now)
        begin
          if (burst_busy)
            st_d.pwr = PWR_SUSPEND;
          else if (all_idle && (cmd == CMD_NOP || cmd == CMD_INHIBIT))
            st_d.pwr = PWR_DOWN;
          else if (all_idle && cmd == CMD_REFRESH)
            st_d.pwr = PWR_SELF_REF;
          else if (all_idle && cmd == CMD_BURST_STOP)
            st_d.pwr = PWR_DEEP;
          else
            st_d.pwr = PWR_DOWN;
        end
        else
        begin
          run = cke_now;
        end
      end
      PWR_DOWN:
      begin
        if (!cke_was && cke_now && (cmd == CMD_NOP || cmd == CMD_INHIBIT))
          st_d.pwr = PWR_RUN;
      end
      PWR_SELF_REF:
      begin
        if (!cke_was && cke_now && (cmd == CMD_NOP || cmd == CMD_INHIBIT))
        begin
          st_d.pwr       = PWR_SR_EXIT;
          st_d.pwr_timer = cyc(XSR_CYC);
        end
      end
      PWR_SR_EXIT:
      begin
        if (cmd != CMD_NOP && cmd != CMD_INHIBIT)
          st_d.illegal = 1'b1;
        if (st_q.pwr_timer <= cyc(1))
          st_d.pwr = PWR_RUN;
        else
          st_d.pwr_timer = st_q.pwr_timer - 1'b1;
      end
      PWR_DEEP:
      begin
        if (!cke_was && cke_now)
          st_d.pwr = PWR_RUN;
      end
      PWR_SUSPEND:
      begin
        // Internal clock frozen; next command seen at the following edge
        if (!cke_was && cke_now)
          st_d.pwr = PWR_RUN;
      end
      PWR_BUSY:
      begin
        if (st_q.pwr_timer <= cyc(1))
          st_d.pwr = PWR_RUN;
        else
          st_d.pwr_timer = st_q.pwr_timer - 1'b1;
      end
      default:
      begin
        st_d.pwr = PWR_RUN;
      end
    endcase

    // Read data pipe shifts in every power state except clock suspend
    if (run || st_q.pwr != PWR_SUSPEND)
    begin
      st_d.rd_pipe      = {st_q.rd_pipe[2:0], 1'b0};
      st_d.rd_bank_pipe = {st_q.rd_bank_pipe[2*BANK_BITS-1:0], {BANK_BITS{1'b0}}};
      st_d.rd_en        = (cas_latency == CAS_LAT_MAX) ? st_q.rd_pipe[2] : st_q.rd_pipe[1];
      st_d.rd_bank      = (cas_latency == CAS_LAT_MAX) ? st_q.rd_bank_pipe[3*BANK_BITS-1 -: BANK_BITS]
                                                      : st_q.rd_bank_pipe[2*BANK_BITS-1 -: BANK_BITS];
    end

    // Per-bank timers and burst counters, independent for each bank
    for (int b = 0; b < NBANK; b++)
    begin
      bs = bank_state_t'(st_q.bank[3*b +: 3]);
      if (run)
      begin
        if (st_q.timer[TIMER_BITS*b +: TIMER_BITS] != '0)
          st_d.timer[TIMER_BITS*b +: TIMER_BITS] = st_q.timer[TIMER_BITS*b +: TIMER_BITS] - 1'b1;
        if (st_q.burst[BURST_BITS*b +: BURST_BITS] != '0)
          st_d.burst[BURST_BITS*b +: BURST_BITS] = st_q.burst[BURST_BITS*b +: BURST_BITS] - 1'b1;
        case (bs)
          BANK_ACTIVATING:
            if (st_q.timer[TIMER_BITS*b +: TIMER_BITS] <= cyc(1))
              st_d.bank[3*b +: 3] = BANK_ACTIVE;
          BANK_READ, BANK_WRITE:
            if (st_q.burst[BURST_BITS*b +: BURST_BITS] <= BURST_BITS'(1))
              st_d.bank[3*b +: 3] = BANK_ACTIVE;
          BANK_READ_AP:
            if (st_q.burst[BURST_BITS*b +: BURST_BITS] <= BURST_BITS'(1))
            begin
              st_d.bank[3*b +: 3] = BANK_PRECHARGE;
              st_d.timer[TIMER_BITS*b +: TIMER_BITS] = cyc(RP_CYC);
            end
          BANK_WRITE_AP:
            if (st_q.burst[BURST_BITS*b +: BURST_BITS] <= BURST_BITS'(1) && !st_q.wr_recover[b])
            begin
              st_d.wr_recover[b] = 1'b1;
              st_d.timer[TIMER_BITS*b +: TIMER_BITS] = cyc(WR_CYC);
            end
            else if (st_q.wr_recover[b] && st_q.timer[TIMER_BITS*b +: TIMER_BITS] <= cyc(1))
            begin
              st_d.wr_recover[b] = 1'b0;
              st_d.bank[3*b +: 3] = BANK_PRECHARGE;
              st_d.timer[TIMER_BITS*b +: TIMER_BITS] = cyc(RP_CYC);
            end
          BANK_PRECHARGE:
            if (st_q.timer[TIMER_BITS*b +: TIMER_BITS] <= cyc(1))
              st_d.bank[3*b +: 3] = BANK_IDLE;
          default:
          begin
          end
        endcase
      end
    end

    // Command execution, only when enable was and is high
    if (run && cke_was)
    begin
      for (int b = 0; b < NBANK; b++)
      begin
        bs = bank_state_t'(st_q.bank[3*b +: 3]);
        cmd_bank_sel = (tb == BANK_BITS'(b));
        if (cmd_bank_sel || (cmd == CMD_PRECHARGE && pa))
        begin
          case (cmd)
            CMD_ACTIVATE:
              if (bs == BANK_IDLE)
              begin
                st_d.bank[3*b +: 3] = BANK_ACTIVATING;
                st_d.timer[TIMER_BITS*b +: TIMER_BITS] = cyc(RCD_CYC);
              end
              else
                st_d.illegal = 1'b1;
            CMD_READ, CMD_WRITE:
              if (bs inside {BANK_ACTIVE, BANK_READ, BANK_WRITE})
              begin
                if (cmd == CMD_READ)
                  st_d.bank[3*b +: 3] = ap ? BANK_READ_AP : BANK_READ;
                else
                  st_d.bank[3*b +: 3] = ap ? BANK_WRITE_AP : BANK_WRITE;
                st_d.burst[BURST_BITS*b +: BURST_BITS] = burst_length;
                st_d.wr_recover[b] = 1'b0;
              end
              else
                st_d.illegal = 1'b1;
            CMD_PRECHARGE:
              if (bs inside {BANK_ACTIVE, BANK_READ, BANK_WRITE, BANK_IDLE})
              begin
                if (bs != BANK_IDLE)
                begin
                  st_d.bank[3*b +: 3] = BANK_PRECHARGE;
                  st_d.timer[TIMER_BITS*b +: TIMER_BITS] = cyc(RP_CYC);
                  st_d.burst[BURST_BITS*b +: BURST_BITS] = '0;
                end
              end
              else if (cmd_bank_sel)
                st_d.illegal = 1'b1;
            CMD_BURST_STOP:
              if (bs inside {BANK_READ, BANK_WRITE})
              begin
                st_d.bank[3*b +: 3] = BANK_ACTIVE;
                st_d.burst[BURST_BITS*b +: BURST_BITS] = '0;
              end
            default:
            begin
            end
          endcase
        end
        else if (cmd == CMD_READ || cmd == CMD_WRITE)
        begin
          // Access elsewhere interrupts this bank's burst
          if (bs == BANK_READ_AP)
          begin
            st_d.bank[3*b +: 3] = BANK_PRECHARGE;
            st_d.timer[TIMER_BITS*b +: TIMER_BITS] = cyc(RP_CYC);
            st_d.burst[BURST_BITS*b +: BURST_BITS] = '0;
          end
          else if (bs == BANK_WRITE_AP && !st_q.wr_recover[b])
          begin
            st_d.wr_recover[b] = 1'b1;
            st_d.timer[TIMER_BITS*b +: TIMER_BITS] = cyc(WR_CYC);
            st_d.burst[BURST_BITS*b +: BURST_BITS] = '0;
          end
          else if (bs inside {BANK_READ, BANK_WRITE})
          begin
            st_d.bank[3*b +: 3] = BANK_ACTIVE;
            st_d.burst[BURST_BITS*b +: BURST_BITS] = '0;
          end
        end
      end
      // Refresh and mode load need every bank idle
      if (cmd == CMD_REFRESH || cmd == CMD_LOAD_MODE)
      begin
        if (!all_idle)
          st_d.illegal = 1'b1;
        else
        begin
          st_d.pwr       = PWR_BUSY;
          st_d.pwr_timer = (cmd == CMD_REFRESH) ? cyc(RC_CYC) : cyc(MODE_LOAD_CYCLES);
        end
      end
      // Read launch: a new read cuts older read data at the same latency
      if (cmd == CMD_READ && !st_d.illegal)
      begin
        st_d.rd_pipe[0] = 1'b1;
        st_d.rd_bank_pipe[BANK_BITS-1:0] = tb;
      end
      if (cmd == CMD_WRITE)
      begin
        st_d.rd_pipe = '0;
        st_d.rd_en   = 1'b0;
      end
    end

    // Write data capture into the FIFO; at an interrupting read or burst stop the data is dropped, at a write it starts the new burst
    for (int b = 0; b < NBANK; b++)
    begin
      bs = bank_state_t'(st_q.bank[3*b +: 3]);
      if (run && (bs == BANK_WRITE || (bs == BANK_WRITE_AP && !st_q.wr_recover[b]))
          && st_q.burst[BURST_BITS*b +: BURST_BITS] > BURST_BITS'(1) && !dat_s2_q[DATA_W]
          && !((cmd == CMD_READ || cmd == CMD_WRITE || cmd == CMD_BURST_STOP) && cke_was))
      begin
        wr_push = 1'b1;
      end
    end
    if (run && cke_was && cmd == CMD_WRITE && !dat_s2_q[DATA_W])
      wr_push = 1'b1;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Accepted write elements leave through the buffer
  sdram_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) sdram_fifo_inst (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (wr_push),
    .in_ready  (fifo_ready),
    .in_data   (wr_push_data),
    .out_valid (wr_out_valid),
    .out_ready (wr_out_ready),
    .out_data  (wr_out_data)
  );

  assign read_data_enable = st_q.rd_en;
  assign read_data_bank   = st_q.rd_bank;
  assign power_state      = st_q.pwr;
  assign bank_states      = st_q.bank;
  assign cmd_illegal      = st_q.illegal;
endmodule
`default_nettype wire

// ==== sdram_bank_checker_assertions.sv ====
// Concurrent checks on the bank state and clock-enable outputs
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_checker
  import sdram_ctl_pkg::*;
#(
  parameter int NBANK = NUM_BANKS
) (
  input wire logic               clock,
  input wire logic               reset,
  input wire logic               cke,
  input wire logic               chip_select_n,
  input wire logic               row_strobe_n,
  input wire logic               col_strobe_n,
  input wire logic               write_enable_n,
  input wire logic [2:0]         power_state,
  input wire logic [3*NBANK-1:0] bank_states
);
  logic [2:0] b0;
  logic [3:0] pins;
  // Bank 0 stands for all; pins are seen three edges before their effect
  assign b0   = bank_states[2:0];
  assign pins = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_activate_len: assert property (b0 == BANK_ACTIVATING && $past(b0) != BANK_ACTIVATING
    |-> (b0 == BANK_ACTIVATING)[*4] ##1 b0 == BANK_ACTIVE) else $error("activation length wrong");
  a_precharge_len: assert property (b0 == BANK_PRECHARGE && $past(b0) != BANK_PRECHARGE
    |-> (b0 == BANK_PRECHARGE)[*4] ##1 b0 == BANK_IDLE) else $error("precharge length wrong");
  a_idle_after_pre: assert property (b0 == BANK_IDLE && $past(b0) != BANK_IDLE
    |-> $past(b0) == BANK_PRECHARGE) else $error("idle entered without precharge");
  a_active_entry: assert property (b0 == BANK_ACTIVE && $past(b0) != BANK_ACTIVE
    |-> $past(b0) inside {BANK_ACTIVATING, BANK_READ, BANK_WRITE}) else $error("bad entry to active");
  a_down_entry: assert property (power_state == PWR_DOWN && $past(power_state) == PWR_RUN
    |-> !$past(cke, 3) && ($past(chip_select_n, 3) || $past(pins, 3) == 4'h7)) else $error("bad power-down entry");
  a_self_entry: assert property (power_state == PWR_SELF_REF && $past(power_state) == PWR_RUN
    |-> !$past(cke, 3) && $past(pins, 3) == 4'h1) else $error("bad self refresh entry");
  a_deep_entry: assert property (power_state == PWR_DEEP && $past(power_state) == PWR_RUN
    |-> !$past(cke, 3) && $past(pins, 3) == 4'h6) else $error("bad deep power-down entry");
  a_down_exit: assert property (power_state == PWR_RUN && $past(power_state) == PWR_DOWN
    |-> $past(cke, 3)) else $error("power-down left with enable low");
  c_deep: cover property (power_state == PWR_DEEP);
  c_read_ap: cover property (b0 == BANK_READ_AP);
  c_write_ap: cover property (b0 == BANK_WRITE_AP);
endmodule
bind sdram_bank_ctrl sdram_bank_checker #(.NBANK(NBANK)) sdram_bank_checker_inst (.*);
`default_nettype wire

// ==== sdram_cmd_driver.sv ====
// Controller-side model that encodes commands onto the device pins
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_driver
  import sdram_ctl_pkg::*;
(
  input  wire logic  clock,
  input  wire cmd_t  cmd,
  output logic       cs_n,
  output logic [2:0] strobes
);
  logic tog_q = 1'b0;
  // Strobes toggle under inhibit so a stale command never looks valid
  always @(posedge clock) tog_q <= !tog_q;
  // Row, column and write strobes per command
  always_comb
  begin
    cs_n = 1'b0;
    case (cmd)
      CMD_NOP:        strobes = 3'h7;
      CMD_ACTIVATE:   strobes = 3'h3;
      CMD_READ:       strobes = 3'h5;
      CMD_WRITE:      strobes = 3'h4;
      CMD_PRECHARGE:  strobes = 3'h2;
      CMD_REFRESH:    strobes = 3'h1;
      CMD_LOAD_MODE:  strobes = 3'h0;
      CMD_BURST_STOP: strobes = 3'h6;
      default:
      begin
        cs_n    = 1'b1;
        strobes = {3{tog_q}};
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== sdram_bank_state_and_cke_logic_tb_top.sv ====
// Self-checking bench for the bank state and clock-enable logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module sdram_bank_state_and_cke_logic_tb_top
  import sdram_ctl_pkg::*;
;
  logic        clock = 1'b0, reset = 1'b1, cke = 1'b1, ap = 1'b0, wr_out_ready = 1'b1;
  logic [1:0]  bank = 2'h0, cas_latency = 2'h2, read_data_bank;
  logic [15:0] write_data = 16'h0000, wr_out_data, dv;
  cmd_t        cmd = CMD_NOP;
  logic        cs_n, wr_out_valid, fifo_ready, read_data_enable, cmd_illegal;
  logic [2:0]  strobes, power_state;
  logic [11:0] bank_states;
  int          num_errors = 0, n_compared = 0, n, cnt;
  int          d[2];
  initial forever #2.5 clock = ~clock;
  // Write data steps every cycle so each captured element is traceable
  always @(posedge clock) write_data <= write_data + 16'h0001;
  sdram_cmd_driver sdram_cmd_driver_inst (.clock(clock), .cmd(cmd), .cs_n(cs_n), .strobes(strobes));
  sdram_bank_ctrl sdram_bank_ctrl_inst (.clock(clock), .reset(reset), .cke(cke), .chip_select_n(cs_n),
    .row_strobe_n(strobes[2]), .col_strobe_n(strobes[1]), .write_enable_n(strobes[0]), .bank_addr(bank),
    .auto_precharge(ap), .all_banks(1'b0), .cas_latency(cas_latency), .burst_length(4'h4),
    .write_data(write_data), .write_mask(1'b0), .wr_out_valid(wr_out_valid), .wr_out_ready(wr_out_ready),
    .wr_out_data(wr_out_data), .fifo_ready(fifo_ready), .read_data_enable(read_data_enable),
    .read_data_bank(read_data_bank), .power_state(power_state), .bank_states(bank_states),
    .cmd_illegal(cmd_illegal));
  function automatic logic [2:0] obs(input int s);
    if (s < 4)
      return bank_states[3*s +: 3];
    if (s == 5)
      return {2'h0, cmd_illegal};
    if (s == 7)
      return {read_data_enable, 1'b0, read_data_bank[0]};
    return power_state;
  endfunction
  task automatic complete_run();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One command for one cycle, then no-operation; dv is the coincident data
  task automatic issue(input cmd_t c, input logic [1:0] b, input logic a, input logic k);
    @(posedge clock);
    cmd <= c;
    bank <= b;
    ap <= a;
    cke <= k;
    #1 dv = write_data;
    @(posedge clock);
    cmd <= CMD_NOP;
  endtask
  // Bounded wait for a watched value; running out ends the run
  task automatic wait_obs(input int s, input logic [2:0] v, input int lim);
    n = 0;
    #1;
    while (obs(s) !== v && n < lim)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK(obs(s), v)
    if (obs(s) !== v)
      complete_run();
  endtask
  task automatic t_activate();
    issue(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1);
    issue(CMD_ACTIVATE, 2'h1, 1'b0, 1'b1);
    wait_obs(0, BANK_ACTIVATING, 1);
    wait_obs(1, BANK_ACTIVE, 12);
    wait_obs(0, BANK_ACTIVE, 0);
    issue(CMD_READ, 2'h2, 1'b0, 1'b1);
    wait_obs(5, 3'h1, 5);
  endtask
  // Read with auto precharge cut by a read elsewhere, at both latencies
  task automatic t_read_ap();
    for (int i = 0; i < 2; i++)
    begin
      cas_latency <= CAS_LAT_MIN + 2'(i);
      issue(CMD_READ, 2'h0, 1'b1, 1'b1);
      issue(CMD_READ, 2'h1, 1'b0, 1'b1);
      wait_obs(0, BANK_PRECHARGE, 3);
      wait_obs(7, 3'h5, 12);
      d[i] = n;
      wait_obs(0, BANK_IDLE, 8);
      issue(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1);
      wait_obs(0, BANK_ACTIVE, 12);
    end
    `CHK(d[1] - d[0], 1)
  endtask
  // Write with auto precharge cut by a write elsewhere while the sink stalls
  task automatic t_write_ap();
    wr_out_ready <= 1'b0;
    wait_obs(1, BANK_ACTIVE, 12);
    issue(CMD_WRITE, 2'h0, 1'b1, 1'b1);
    d[0] = dv;
    issue(CMD_WRITE, 2'h1, 1'b0, 1'b1);
    wait_obs(0, BANK_IDLE, 20);
    wait_obs(1, BANK_ACTIVE, 12);
    wr_out_ready <= 1'b1;
    `CHK(fifo_ready, 1'b1)
    cnt = 0;
    for (int i = 0; i < 12; i++)
    begin
      if (wr_out_valid === 1'b1 && cnt == 0)
        `CHK(wr_out_data, 16'(d[0]))
      if (wr_out_valid === 1'b1)
        cnt++;
      @(posedge clock);
      #1;
    end
    `CHK(cnt, 6)
  endtask
  task automatic t_trunc();
    issue(CMD_READ, 2'h1, 1'b0, 1'b1);
    issue(CMD_NOP, 2'h1, 1'b0, 1'b0);
    wait_obs(4, PWR_SUSPEND, 6);
    issue(CMD_NOP, 2'h1, 1'b0, 1'b1);
    wait_obs(1, BANK_READ, 0);
    issue(CMD_PRECHARGE, 2'h1, 1'b0, 1'b1);
    wait_obs(1, BANK_PRECHARGE, 4);
    wait_obs(1, BANK_IDLE, 8);
  endtask
  // Power states; exit from self refresh is padded with no-operations only
  task automatic t_power();
    issue(CMD_NOP, 2'h0, 1'b0, 1'b0);
    wait_obs(4, PWR_DOWN, 6);
    issue(CMD_NOP, 2'h0, 1'b0, 1'b1);
    wait_obs(4, PWR_RUN, 6);
    issue(CMD_REFRESH, 2'h0, 1'b0, 1'b0);
    wait_obs(4, PWR_SELF_REF, 6);
    issue(CMD_NOP, 2'h0, 1'b0, 1'b1);
    wait_obs(4, PWR_RUN, 40);
    issue(CMD_BURST_STOP, 2'h0, 1'b0, 1'b0);
    wait_obs(4, PWR_DEEP, 6);
  endtask
  // Reset for three cycles, then the scenarios in turn
  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    t_activate();
    t_read_ap();
    t_write_ap();
    t_trunc();
    t_power();
    complete_run();
  end
endmodule
`default_nettype wire
